// ---- core/ir_interrupt_ident.sv ----
// Purpose: Interrupt identification byte of a serial infrared controller
// Assumes: FIFO levels and event pulses come from logic on aclk
// Notes:   Terminal count arrives from a pin and is synchronised
`timescale 1ns/1ps
module ir_interrupt_ident
    import ir_ident_pkg::*;
#(
    parameter int unsigned LEVEL_W    = 7,
    parameter int unsigned PEND_W     = 4,
    parameter int unsigned AXI_ADDR_W = 4
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [LEVEL_W-1:0]    rx_level,
    input  wire logic [LEVEL_W-1:0]    tx_level,
    input  wire logic                  rx_byte_arrive,
    input  wire logic                  rx_fifo_full,
    input  wire logic                  rx_eof_detect,
    input  wire logic                  rx_last_byte_read,
    input  wire logic                  overrun_service,
    input  wire logic                  tx_underrun,
    input  wire logic                  underrun_service,
    input  wire logic                  sq_timeout_event,
    input  wire logic                  sq_threshold_event,
    input  wire logic                  status_queue_read,
    input  wire logic                  terminal_count,
    output logic                       rx_accept_enable,
    output logic [7:0]                 interrupt_ident_byte
);

    if (LEVEL_W < 1 || LEVEL_W > THR_W) begin : g_chk_level
        $error("LEVEL_W must lie between 1 and THR_W");
    end
    if (PEND_W < 1) begin : g_chk_pend
        $error("PEND_W must be at least 1");
    end
    if (AXI_ADDR_W < 4) begin : g_chk_addr
        $error("AXI_ADDR_W must be at least 4");
    end

    // Address decode helpers
    function automatic logic hit(input logic [AXI_ADDR_W-1:0] a, input logic [3:0] off);
        logic [AXI_ADDR_W-1:0] ext;
        ext = AXI_ADDR_W'(off);
        hit = (a[AXI_ADDR_W-1:2] == ext[AXI_ADDR_W-1:2]);
    endfunction : hit

    // Control register and mode
    logic [31:0]       ctrl_ff;
    logic [31:0]       nxt_ctrl;
    mode_type          mode;
    logic [THR_W-1:0]  rx_thr;
    logic [THR_W-1:0]  tx_thr;

    always_comb begin
        if (ctrl_ff[CTRL_DMA_BIT]) begin
            mode = MODE_DMA;
        end else if (ctrl_ff[CTRL_REMOTE_BIT]) begin
            mode = MODE_REMOTE;
        end else begin
            mode = MODE_PIO;
        end
    end

    assign rx_thr = ctrl_ff[CTRL_RXT_LSB +: THR_W];
    assign tx_thr = ctrl_ff[CTRL_TXT_LSB +: THR_W];

    // Write channel state
    logic                  aw_held_ff;
    logic                  nxt_aw_held;
    logic [AXI_ADDR_W-1:0] awaddr_ff;
    logic [AXI_ADDR_W-1:0] nxt_awaddr;
    logic                  w_held_ff;
    logic                  nxt_w_held;
    logic [31:0]           wdata_ff;
    logic [31:0]           nxt_wdata;
    logic [3:0]            wstrb_ff;
    logic [3:0]            nxt_wstrb;
    logic                  bvalid_ff;
    logic                  nxt_bvalid;
    logic [1:0]            bresp_ff;
    logic [1:0]            nxt_bresp;
    logic                  do_write;

    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready  = !w_held_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;

    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_w_held  = w_held_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_ctrl    = ctrl_ff;
        if (s_axi_bvalid && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (do_write) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = RESP_SLVERR;
            if (hit(awaddr_ff, ADDR_CTRL)) begin
                nxt_bresp = RESP_OKAY;
                for (int i = 0; i < 4; i++) begin
                    if (wstrb_ff[i]) begin
                        nxt_ctrl[8*i +: 8] = wdata_ff[8*i +: 8];
                    end
                end
                nxt_ctrl = nxt_ctrl & CTRL_MASK;
            end
        end
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_held = 1'b1;
            nxt_awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_held = 1'b1;
            nxt_wdata  = s_axi_wdata;
            nxt_wstrb  = s_axi_wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= '0;
            w_held_ff  <= 1'b0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            ctrl_ff    <= CTRL_RESET;
        end else begin
            aw_held_ff <= nxt_aw_held;
            awaddr_ff  <= nxt_awaddr;
            w_held_ff  <= nxt_w_held;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            ctrl_ff    <= nxt_ctrl;
        end
    end

    // Terminal count synchroniser and filter
    logic [SYNC_STAGES-1:0] tc_sync_ff;
    logic [SYNC_STAGES-1:0] nxt_tc_sync;
    logic                   tc_level_ff;
    logic                   nxt_tc_level;
    logic                   tc_rise;

    always_comb begin
        nxt_tc_sync  = {tc_sync_ff[SYNC_STAGES-2:0], terminal_count};
        nxt_tc_level = tc_level_ff;
        if (tc_sync_ff[1] == tc_sync_ff[2]) begin
            nxt_tc_level = tc_sync_ff[2];
        end
        tc_rise = !tc_level_ff && tc_sync_ff[1] && tc_sync_ff[2];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tc_sync_ff  <= '0;
            tc_level_ff <= 1'b0;
        end else begin
            tc_sync_ff  <= nxt_tc_sync;
            tc_level_ff <= nxt_tc_level;
        end
    end

    // Read channel and identification byte
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0]  rresp_ff;
    logic [1:0]  nxt_rresp;
    logic        ident_read;
    logic [7:0]  ident_view;

    logic        rx_over;
    logic        tx_below;
    logic        last_read_ff;
    logic        eof_ff;
    logic        overrun_ff;
    logic        underrun_ff;
    logic        sq_to_ff;
    logic        sq_thr_ff;
    logic        tc_ff;

    assign rx_over  = (THR_W'(rx_level) >= rx_thr);
    assign tx_below = (THR_W'(tx_level) < tx_thr);

    always_comb begin
        ident_view = 8'h00;
        unique case (mode)
            MODE_PIO: begin
                ident_view[BIT_RX_THR]    = rx_over;
                ident_view[BIT_TX_THR]    = tx_below;
                ident_view[BIT_LAST_READ] = last_read_ff;
                ident_view[BIT_OVERRUN]   = overrun_ff;
                ident_view[BIT_UNDERRUN]  = underrun_ff;
                ident_view[BIT_EOF]       = eof_ff;
            end
            MODE_DMA: begin
                ident_view[BIT_SQ_TIMEOUT] = sq_to_ff;
                ident_view[BIT_SQ_THR]     = sq_thr_ff;
                ident_view[BIT_UNDERRUN]   = underrun_ff;
                ident_view[BIT_TC]         = tc_ff;
            end
            MODE_REMOTE: begin
                ident_view[BIT_RX_THR]   = rx_over;
                ident_view[BIT_TX_THR]   = tx_below;
                ident_view[BIT_OVERRUN]  = overrun_ff;
                ident_view[BIT_UNDERRUN] = underrun_ff;
            end
        endcase
    end

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign ident_read    = s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, ADDR_IDENT);
    assign interrupt_ident_byte = ident_view;

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (s_axi_rvalid && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            if (ident_read) begin
                nxt_rdata = {24'h000000, ident_view};
            end else if (hit(s_axi_araddr, ADDR_CTRL)) begin
                nxt_rdata = ctrl_ff & CTRL_MASK;
            end else begin
                nxt_rdata = 32'h0000_0000;
                nxt_rresp = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end
    end

    // Sticky flags, set wins over clear
    logic              nxt_last_read;
    logic              nxt_eof;
    logic              nxt_overrun;
    logic              nxt_underrun;
    logic              nxt_sq_to;
    logic              nxt_sq_thr;
    logic              nxt_tc;
    logic [PEND_W-1:0] eof_pend_ff;
    logic [PEND_W-1:0] nxt_eof_pend;
    logic              is_pio;
    logic              is_dma;
    logic              last_ok;

    assign is_pio           = (mode == MODE_PIO);
    assign is_dma           = (mode == MODE_DMA);
    assign last_ok          = is_pio && rx_last_byte_read && (eof_pend_ff != '0);
    assign rx_accept_enable = !overrun_ff;

    always_comb begin
        nxt_last_read = last_read_ff;
        nxt_eof       = eof_ff;
        nxt_overrun   = overrun_ff;
        nxt_underrun  = underrun_ff;
        nxt_sq_to     = sq_to_ff;
        nxt_sq_thr    = sq_thr_ff;
        nxt_tc        = tc_ff;
        nxt_eof_pend  = eof_pend_ff;
        if (is_pio && ident_read) begin
            nxt_last_read = 1'b0;
            nxt_eof       = 1'b0;
        end
        if (last_ok) begin
            nxt_last_read = 1'b1;
        end
        if (is_pio && rx_eof_detect) begin
            nxt_eof = 1'b1;
        end
        if (last_ok && !(is_pio && rx_eof_detect)) begin
            nxt_eof_pend = eof_pend_ff - PEND_W'(1);
        end else if (!last_ok && is_pio && rx_eof_detect && (eof_pend_ff != '1)) begin
            nxt_eof_pend = eof_pend_ff + PEND_W'(1);
        end
        if (overrun_service) begin
            nxt_overrun = 1'b0;
        end
        if (!is_dma && rx_byte_arrive && rx_fifo_full) begin
            nxt_overrun = 1'b1;
        end
        if (underrun_service) begin
            nxt_underrun = 1'b0;
        end
        if (tx_underrun) begin
            nxt_underrun = 1'b1;
        end
        if (status_queue_read) begin
            nxt_sq_to  = 1'b0;
            nxt_sq_thr = 1'b0;
            nxt_tc     = 1'b0;
        end
        if (is_dma && sq_timeout_event) begin
            nxt_sq_to = 1'b1;
        end
        if (is_dma && sq_threshold_event) begin
            nxt_sq_thr = 1'b1;
        end
        if (is_dma && tc_rise) begin
            nxt_tc = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_read_ff <= 1'b0;
            eof_ff       <= 1'b0;
            overrun_ff   <= 1'b0;
            underrun_ff  <= 1'b0;
            sq_to_ff     <= 1'b0;
            sq_thr_ff    <= 1'b0;
            tc_ff        <= 1'b0;
            eof_pend_ff  <= '0;
        end else begin
            last_read_ff <= nxt_last_read;
            eof_ff       <= nxt_eof;
            overrun_ff   <= nxt_overrun;
            underrun_ff  <= nxt_underrun;
            sq_to_ff     <= nxt_sq_to;
            sq_thr_ff    <= nxt_sq_thr;
            tc_ff        <= nxt_tc;
            eof_pend_ff  <= nxt_eof_pend;
        end
    end

endmodule : ir_interrupt_ident

// ---- core/ir_ident_pkg.sv ----
// Purpose: Shared constants for the interrupt identification block
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   Byte address of a register is four times its index
package ir_ident_pkg;

    // Register map
    localparam int unsigned      IDX_IDENT  = 2;
    localparam logic [3:0]       ADDR_IDENT = 4'(4 * IDX_IDENT);
    localparam logic [3:0]       ADDR_CTRL  = 4'hC;

    // Identification byte layout
    localparam int unsigned      BIT_RX_THR     = 0;
    localparam int unsigned      BIT_TX_THR     = 1;
    localparam int unsigned      BIT_LAST_READ  = 2;
    localparam int unsigned      BIT_SQ_TIMEOUT = 2;
    localparam int unsigned      BIT_OVERRUN    = 3;
    localparam int unsigned      BIT_SQ_THR     = 4;
    localparam int unsigned      BIT_UNDERRUN   = 5;
    localparam int unsigned      BIT_TC         = 6;
    localparam int unsigned      BIT_EOF        = 7;

    // Control register layout
    localparam int unsigned      CTRL_DMA_BIT    = 3;
    localparam int unsigned      CTRL_REMOTE_BIT = 4;
    localparam int unsigned      CTRL_RXT_LSB    = 8;
    localparam int unsigned      CTRL_TXT_LSB    = 16;
    localparam int unsigned      THR_W           = 8;
    localparam logic [31:0]      CTRL_MASK       = 32'h00FF_FF18;
    localparam logic [31:0]      CTRL_RESET      = 32'h0001_0100;

    // AXI responses
    localparam logic [1:0]       RESP_OKAY   = 2'h0;
    localparam logic [1:0]       RESP_SLVERR = 2'h2;

    // Terminal count synchroniser depth
    localparam int unsigned      SYNC_STAGES = 3;

    typedef enum logic [2:0] {
        MODE_PIO    = 3'h1,
        MODE_DMA    = 3'h2,
        MODE_REMOTE = 3'h4
    } mode_type;

endpackage : ir_ident_pkg

// ---- tb/ir_ident_asserts.sv ----
// Purpose: Port-level checks of the interrupt identification block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
module ir_ident_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        rx_byte_arrive,
    input wire logic        overrun_service,
    input wire logic        tx_underrun,
    input wire logic        underrun_service,
    input wire logic        rx_accept_enable,
    input wire logic [7:0]  interrupt_ident_byte
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    AST_OVR_HOLD:
        assert property (!rx_accept_enable && !overrun_service |=> !rx_accept_enable)
        else $error("receive accepted before overrun service");
    AST_OVR_SVC:
        assert property (overrun_service && !rx_byte_arrive |=> rx_accept_enable)
        else $error("receive still blocked after service");
    AST_UND_SET:
        assert property (tx_underrun && !underrun_service |=> interrupt_ident_byte[5])
        else $error("underrun flag not set");
    AST_UND_HOLD:
        assert property (interrupt_ident_byte[5] && !underrun_service |=> interrupt_ident_byte[5])
        else $error("underrun flag dropped without service");
    AST_UND_CLR:
        assert property (underrun_service && !tx_underrun |=> !interrupt_ident_byte[5])
        else $error("underrun flag not cleared");
    AST_R_LAT:
        assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_HOLD:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_B_LAT:
        assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer timing wrong");
    AST_B_HOLD:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
endmodule : ir_ident_asserts

bind ir_interrupt_ident ir_ident_asserts u_chk (.*);

// ---- tb/host_axi_master.sv ----
// Purpose: Host CPU model issuing AXI4-Lite register cycles
// Assumes: Slave readies change only on rising edges
// Notes:   Handshakes and answers taken at the rising edge itself
`timescale 1ns/1ps
module host_axi_master (
    input  wire logic        aclk,
    output logic [3:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [3:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, got;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            got = s_axi_bvalid;
            r = s_axi_bresp;
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, got;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            got = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : host_axi_master

// ---- tb/tb.sv ----
// Purpose: Self-checking bench of the interrupt identification block
// Assumes: Event inputs are single-cycle pulses on aclk
// Notes:   Table rows cover levels and layouts, flags tested by hand
`timescale 1ns/1ps
module tb
    import ir_ident_pkg::*;
;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [6:0]  rx;
        logic [6:0]  tx;
        logic [7:0]  exp;
    } row_type;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [6:0]  rx_level, tx_level;
    logic        rx_byte_arrive, rx_eof_detect, rx_last_byte_read, overrun_service;
    logic        tx_underrun, underrun_service, sq_timeout_event, sq_threshold_event;
    logic        status_queue_read, rx_fifo_full, terminal_count, rx_accept_enable;
    logic [7:0]  interrupt_ident_byte;
    logic [8:0]  ev;
    int          error_cnt = 0;
    int          total_checks = 0;
    row_type     rows [6] = '{
        '{32'h0001_0100, 7'h00, 7'h00, 8'h02}, '{32'h0001_0100, 7'h01, 7'h00, 8'h03},
        '{32'h0004_0400, 7'h03, 7'h04, 8'h00}, '{32'h0004_0400, 7'h04, 7'h03, 8'h03},
        '{32'h0004_0410, 7'h04, 7'h03, 8'h03}, '{32'h0004_0408, 7'h04, 7'h03, 8'h00}};

    assign {rx_byte_arrive, rx_eof_detect, rx_last_byte_read, overrun_service, tx_underrun,
            underrun_service, sq_timeout_event, sq_threshold_event, status_queue_read} = ev;

    ir_interrupt_ident i_ir_interrupt_ident (.*);
    host_axi_master    u_host (.*);

    always #2 aclk = ~aclk;

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk

    task automatic cb(input logic [7:0] e);
        #1;
        chk({24'h0, interrupt_ident_byte}, {24'h0, e});
    endtask : cb

    task automatic pulse(input logic [8:0] v);
        @(posedge aclk);
        ev <= v;
        @(posedge aclk);
        ev <= '0;
        @(posedge aclk);
    endtask : pulse

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        {rx_level, tx_level, rx_fifo_full, terminal_count, ev} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cb(8'h02);
        chk({31'h0, rx_accept_enable}, 32'h1);
        u_host.rd(ADDR_CTRL, d, r);
        chk(d, CTRL_RESET);
        $display("test reset done");
        foreach (rows[i]) begin
            u_host.wr(ADDR_CTRL, rows[i].ctrl, r);
            chk({30'h0, r}, {30'h0, RESP_OKAY});
            @(posedge aclk);
            rx_level <= rows[i].rx;
            tx_level <= rows[i].tx;
            u_host.rd(ADDR_IDENT, d, r);
            chk(d, {24'h0, rows[i].exp});
            cb(rows[i].exp);
        end
        u_host.wr(ADDR_CTRL, CTRL_RESET, r);
        rx_level <= 7'h00;
        tx_level <= 7'h00;
        $display("test table done");
        pulse(9'h040);
        cb(8'h02);
        pulse(9'h080);
        cb(8'h82);
        pulse(9'h040);
        cb(8'h86);
        u_host.rd(ADDR_IDENT, d, r);
        chk(d, 32'h0000_0086);
        cb(8'h02);
        $display("test frame done");
        rx_fifo_full <= 1'b1;
        pulse(9'h100);
        cb(8'h0A);
        pulse(9'h100);
        chk({31'h0, rx_accept_enable}, 32'h0);
        rx_fifo_full <= 1'b0;
        pulse(9'h020);
        cb(8'h02);
        chk({31'h0, rx_accept_enable}, 32'h1);
        pulse(9'h010);
        repeat (5) @(posedge aclk);
        cb(8'h22);
        pulse(9'h008);
        cb(8'h02);
        $display("test overrun underrun done");
        u_host.wr(ADDR_CTRL, 32'h0001_0110, r);
        pulse(9'h080);
        pulse(9'h040);
        cb(8'h02);
        u_host.wr(ADDR_CTRL, 32'h0001_0108, r);
        cb(8'h00);
        pulse(9'h096);
        cb(8'h34);
        terminal_count <= 1'b1;
        repeat (8) @(posedge aclk);
        terminal_count <= 1'b0;
        cb(8'h74);
        pulse(9'h001);
        cb(8'h20);
        pulse(9'h008);
        cb(8'h00);
        $display("test layouts done");
        u_host.wr(ADDR_CTRL, CTRL_RESET, r);
        u_host.wr(ADDR_IDENT, 32'h0000_00FF, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        cb(8'h02);
        u_host.rd(4'h4, d, r);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR});
        $display("test bus done");
        end_of_test();
    end
endmodule : tb
